// ==== core/ulx_pkg.sv ====
// package for the serial line-mode extension block: register map, field layout,
// mode codes, timing fractions and the packed state of the top module.
// assumes a transceiver core beside it that supplies a 16x oversample tick.
package ulx_pkg;

   // register byte addresses on the plain register port
   localparam logic [7:0] ADDR_CMD = 8'h00;    // command register, write-only
   localparam logic [7:0] ADDR_MODE = 8'h04;   // line mode register
   localparam logic [7:0] ADDR_STAT = 8'h14;   // channel status register, read-only
   localparam logic [7:0] ADDR_GUARD = 8'h28;  // guard time length in bit periods
   localparam logic [7:0] ADDR_IRF = 8'h4C;    // ir filter register

   // mode codes held in the line mode register
   localparam logic [3:0] MODE_NORMAL = 4'h0;
   localparam logic [3:0] MODE_LINE_DRV = 4'h1;
   localparam logic [3:0] MODE_MODEM = 4'h3;
   localparam logic [3:0] MODE_IR = 4'h8;
   localparam logic [3:0] MODE_SPI_MST = 4'hE;
   localparam logic [3:0] MODE_SPI_SLV = 4'hF;

   // line mode register fields
   localparam int MODE_LSB = 0;         // mode code, 4 bits
   localparam int MODE_FILTER_BIT = 4;  // ir receive majority filter
   localparam int MODE_NACK_LIM_BIT = 5; // nack_limit_enable
   localparam int MODE_RETRY_EXHAUSTED_FLAG_LSB = 8;    // retry limit field
   localparam int RETRY_EXHAUSTED_FLAG_W = 3;

   // command register bits, each acts when written as one
   localparam int CMD_CLR_RETRY = 0;    // clear_retry_flag_cmd
   localparam int CMD_DTR_ASSERT = 1;   // terminal_ready_assert_cmd
   localparam int CMD_DTR_RELEASE = 2;  // terminal_ready_release_cmd

   // channel status register fields
   localparam int STAT_RETRY = 0;       // retry_exhausted_flag
   localparam int STAT_CHG_LSB = 2;     // cts, set ready, carrier, ring change flags
   localparam int STAT_LVL_LSB = 8;     // present cts, dsr, dcd, ri levels
   localparam int STAT_TX_HOLD = 12;    // transmitter held off by cts
   localparam int STAT_NSS = 13;        // present select line level

   // synchroniser lane order
   localparam int IN_RXD = 0;
   localparam int IN_CTS = 1;
   localparam int IN_W = 5;

   // oversampling and infrared timing
   localparam logic [3:0] OS_LAST = 4'hF;       // 16 oversample ticks per bit
   localparam logic [3:0] IR_PULSE_OS = 4'h3;   // zero bit pulse is 3 of 16 ticks
   localparam int unsigned IR_MIN_BPS = 2400;   // lowest supported infrared rate
   localparam int unsigned IR_MAX_BPS = 115200; // highest supported infrared rate

   // reset values
   localparam logic DTR_RESET = 1'b1;           // terminal ready released
   localparam logic [7:0] BYTE_RESET = 8'h00;

   // select line sequencer for peripheral-interface master mode
   typedef enum logic [1:0] {NSS_IDLE, NSS_LEAD, NSS_XFER, NSS_TRAIL} ulx_nss_t;

   // whole state of the top module
   typedef struct packed {
      logic [3:0] mode;
      logic rx_filt;
      logic nack_lim;
      logic [RETRY_EXHAUSTED_FLAG_W-1:0] max_retry_exhausted_flag;
      logic [7:0] guard;
      logic [7:0] ir_filter;
      logic retry_flag;
      logic [RETRY_EXHAUSTED_FLAG_W-1:0] tx_cnt;
      logic [RETRY_EXHAUSTED_FLAG_W-1:0] rx_cnt;
      logic [3:0] chg;
      logic [IN_W-1:0] s1;
      logic [IN_W-1:0] s2;
      logic [IN_W-1:0] s3;
      logic [IN_W-1:0] lvl;
      logic [1:0] rx_hist;
      logic rx_prev;
      logic [3:0] phase;
      logic tx_bit;
      logic [7:0] ir_cnt;
      logic ir_run;
      logic ir_force;
      logic [3:0] ir_ticks;
      logic rx_out;
      logic txd;
      logic tx_idle_d;
      logic [7:0] gcnt;
      logic rts;
      logic dtr;
      logic tx_hold;
      ulx_nss_t nss_st;
      logic resend;
      logic nack;
      logic accept;
      logic spi_go;
      logic [31:0] rdata;
   } ulx_state_t;

endpackage : ulx_pkg

// ==== core/ulx_line_ext.sv ====
// line-mode extensions for a serial transceiver: smart-card repetition and
// nack limiting, infrared modulator and demodulator, line-driver enable,
// terminal-side modem lines and the master select line.
// assumes a transceiver core on the same clock that reports character ends,
// nacks and parity errors as one-cycle pulses and gives a 16x oversample tick.
//
// How it works
// - nonzero retry limit resends nacked characters
// - limit reached sets flag; command clears it
// - nack limit: accept character, set flag
// - mode 0x8 is infrared, fixed 8N1
// - infrared from 2.4 to 115.2 kbit/s
// - zero bit sends a 3/16 pulse
// - 8-bit counter runs from receive falling edge
// - rising edge stops and reloads the counter
// - counter at zero forces receive low one bit
// - filter bit takes majority of three samples
// - mode 0x1 is line-driver control
// - request-to-send is inverse of transmitter idle
// - request-to-send held high for guard time
// - mode 0x3 is terminal-side modem mode
// - commands assert or release terminal ready
// - modem input change sets its change flag
// - status read clears the four change flags
// - cts high stops transmitter after current character
// - modes 0xE and 0xF are master and slave
// - master drives a single select output
// - receiver nack is one low bit in guard
// - select low one bit before, high one after
//
// The register addresses and the address-and-strobe port were left to the implementer.
module ulx_line_ext (
   // clock, reset and clock enable
   input wire logic I_CORE_CLK,
   input wire logic I_RSTN,
   input wire logic I_CLK_EN,
   // register port
   input wire logic [7:0] I_ADDR,
   input wire logic [31:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   output logic [31:0] O_RDATA,
   // transceiver core status
   input wire logic I_OS_TICK,
   input wire logic I_TX_SERIAL,
   input wire logic I_TX_IDLE,
   input wire logic I_TX_BUSY,
   input wire logic I_TX_CHAR_DONE,
   input wire logic I_TX_NACK,
   input wire logic I_RX_CHAR_DONE,
   input wire logic I_RX_PAR_ERR,
   input wire logic I_SPI_REQ,
   // transceiver core control
   output logic O_RX_SERIAL,
   output logic O_TX_RESEND,
   output logic O_RX_SEND_NACK,
   output logic O_RX_ACCEPT,
   output logic O_TX_HOLD,
   output logic O_SPI_GO,
   output logic O_IR_MODE,
   output logic O_SPI_MASTER,
   output logic O_SPI_SLAVE,
   // pins
   input wire logic I_RXD,
   input wire logic I_CTS,
   input wire logic I_DSR,
   input wire logic I_DCD,
   input wire logic I_RI,
   output logic O_TXD,
   output logic O_RTS,
   output logic O_DTR
);

   ulx_pkg::ulx_state_t q;       // registered state
   ulx_pkg::ulx_state_t next_q;  // next state

   // majority of three samples
   function automatic logic maj3(input logic a, input logic b, input logic c);
      maj3 = (a & b) | (a & c) | (b & c);
   endfunction

   // saturating-free decrement of an 8-bit count
   function automatic logic [7:0] dec8(input logic [7:0] v);
      dec8 = v - 8'h01;
   endfunction

   // mode decodes, plain compares against the held mode code
   logic is_ir;
   logic is_line_drv;
   logic is_modem;
   logic is_spi_mst;
   logic is_spi_slv;
   assign is_ir = (q.mode == ulx_pkg::MODE_IR);
   assign is_line_drv = (q.mode == ulx_pkg::MODE_LINE_DRV);
   assign is_modem = (q.mode == ulx_pkg::MODE_MODEM);
   assign is_spi_mst = (q.mode == ulx_pkg::MODE_SPI_MST);
   assign is_spi_slv = (q.mode == ulx_pkg::MODE_SPI_SLV);

   // next-state logic for the whole block
   always_comb begin
      logic [ulx_pkg::IN_W-1:0] lvl_new;
      logic rx_smp;
      logic bit_tick;
      logic wr_cmd;
      logic [3:0] chg_set;
      lvl_new = q.lvl;
      rx_smp = 1'b1;
      bit_tick = 1'b0;
      wr_cmd = 1'b0;
      chg_set = 4'h0;
      next_q = q;

      // one-cycle strobes default low
      next_q.resend = 1'b0;
      next_q.nack = 1'b0;
      next_q.accept = 1'b0;
      next_q.spi_go = 1'b0;

      // register writes
      if (I_WR) begin
         case (I_ADDR)
            ulx_pkg::ADDR_CMD: begin
               wr_cmd = 1'b1;
            end
            ulx_pkg::ADDR_MODE: begin
               next_q.mode = I_WDATA[ulx_pkg::MODE_LSB +: 4];
               next_q.rx_filt = I_WDATA[ulx_pkg::MODE_FILTER_BIT];
               next_q.nack_lim = I_WDATA[ulx_pkg::MODE_NACK_LIM_BIT];
               next_q.max_retry_exhausted_flag = I_WDATA[ulx_pkg::MODE_RETRY_EXHAUSTED_FLAG_LSB +: ulx_pkg::RETRY_EXHAUSTED_FLAG_W];
            end
            ulx_pkg::ADDR_GUARD: begin
               next_q.guard = I_WDATA[7:0];
            end
            ulx_pkg::ADDR_IRF: begin
               next_q.ir_filter = I_WDATA[7:0];
            end
            default: begin
               // unmapped writes are dropped
            end
         endcase
      end

      // terminal ready commands; a write of both leaves the line released
      if (wr_cmd && I_WDATA[ulx_pkg::CMD_DTR_ASSERT]) begin
         next_q.dtr = 1'b0;
      end
      if (wr_cmd && I_WDATA[ulx_pkg::CMD_DTR_RELEASE]) begin
         next_q.dtr = 1'b1;
      end

      // pin synchronisers: a change counts once stages two and three agree
      next_q.s1 = {I_RI, I_DCD, I_DSR, I_CTS, I_RXD};
      next_q.s2 = q.s1;
      next_q.s3 = q.s2;
      for (int i = 0; i < ulx_pkg::IN_W; i++) begin
         if (q.s2[i] == q.s3[i]) begin
            lvl_new[i] = q.s3[i];
         end
      end
      next_q.lvl = lvl_new;

      // modem input changes; cts, dsr, dcd, ri sit above the receive lane
      chg_set = lvl_new[ulx_pkg::IN_W-1:ulx_pkg::IN_CTS] ^ q.lvl[ulx_pkg::IN_W-1:ulx_pkg::IN_CTS];
      if (is_modem) begin
         next_q.chg = q.chg | chg_set;
      end

      // oversample phase; bit tick closes each 16-tick bit period
      if (I_OS_TICK) begin
         next_q.phase = q.phase + 4'h1;
         bit_tick = (q.phase == ulx_pkg::OS_LAST);
      end

      // receive sample, with optional three-sample majority
      next_q.rx_hist = {q.rx_hist[0], q.lvl[ulx_pkg::IN_RXD]};
      if (q.rx_filt) begin
         rx_smp = maj3(q.lvl[ulx_pkg::IN_RXD], q.rx_hist[0], q.rx_hist[1]);
      end else begin
         rx_smp = q.lvl[ulx_pkg::IN_RXD];
      end
      next_q.rx_prev = rx_smp;

      // infrared demodulator: count the low pulse, reload when idle
      if (!q.ir_run) begin
         next_q.ir_cnt = q.ir_filter;
         if (is_ir && q.rx_prev && !rx_smp) begin
            next_q.ir_run = 1'b1;
         end
      end else if (!q.rx_prev && rx_smp) begin
         // short pulse ended early: treated as noise
         next_q.ir_run = 1'b0;
         next_q.ir_cnt = q.ir_filter;
      end else if (q.ir_cnt == ulx_pkg::BYTE_RESET) begin
         next_q.ir_run = 1'b0;
         next_q.ir_cnt = q.ir_filter;
         next_q.ir_force = 1'b1;
         next_q.ir_ticks = ulx_pkg::OS_LAST;
      end else begin
         next_q.ir_cnt = dec8(q.ir_cnt);
      end

      // forced low lasts 16 oversample ticks, one bit period
      if (q.ir_force && I_OS_TICK) begin
         if (q.ir_ticks == 4'h0) begin
            next_q.ir_force = 1'b0;
         end else begin
            next_q.ir_ticks = q.ir_ticks - 4'h1;
         end
      end

      // receiver input: demodulated in infrared, plain sample otherwise
      if (is_ir) begin
         next_q.rx_out = ~q.ir_force;
      end else begin
         next_q.rx_out = rx_smp;
      end

      // infrared modulator: latch each new bit, pulse only for a zero
      if (bit_tick) begin
         next_q.tx_bit = I_TX_SERIAL;
      end
      if (is_ir) begin
         // the light pulse is active high on the transmit pin
         next_q.txd = ~q.tx_bit && (q.phase < ulx_pkg::IR_PULSE_OS);
      end else begin
         next_q.txd = I_TX_SERIAL;
      end

      // clear first, so that a failure in this same cycle sets the flag again
      if (wr_cmd && I_WDATA[ulx_pkg::CMD_CLR_RETRY]) begin
         next_q.retry_flag = 1'b0;
      end

      // transmit repetition on nack, counting consecutive failures
      if (I_TX_CHAR_DONE) begin
         if (!I_TX_NACK) begin
            next_q.tx_cnt = '0;
         end else if (q.max_retry_exhausted_flag != '0) begin
            if (q.tx_cnt < q.max_retry_exhausted_flag) begin
               next_q.resend = 1'b1;
               next_q.tx_cnt = q.tx_cnt + 1'b1;
            end else begin
               next_q.retry_flag = 1'b1;
               next_q.tx_cnt = '0;
            end
         end
      end

      // receive nack generation, optionally capped by the retry limit
      if (I_RX_CHAR_DONE) begin
         if (!I_RX_PAR_ERR) begin
            next_q.accept = 1'b1;
            next_q.rx_cnt = '0;
         end else if (q.nack_lim && (q.rx_cnt >= q.max_retry_exhausted_flag)) begin
            next_q.accept = 1'b1;
            next_q.retry_flag = 1'b1;
            next_q.rx_cnt = '0;
         end else begin
            // the core drives one low bit inside the guard time
            next_q.nack = 1'b1;
            next_q.rx_cnt = q.rx_cnt + 1'b1;
         end
      end

      // line-driver guard: reload on the idle rise, count in bit periods
      next_q.tx_idle_d = I_TX_IDLE;
      if (I_TX_IDLE && !q.tx_idle_d) begin
         next_q.gcnt = q.guard;
      end else if (bit_tick && (q.gcnt != ulx_pkg::BYTE_RESET)) begin
         next_q.gcnt = dec8(q.gcnt);
      end

      // cts high: let the running character end, then hold the transmitter
      if (is_modem && lvl_new[ulx_pkg::IN_CTS]) begin
         if (!I_TX_BUSY) begin
            next_q.tx_hold = 1'b1;
         end
      end else begin
         next_q.tx_hold = 1'b0;
      end

      // master select sequencer, stepping on bit periods
      case (q.nss_st)
         ulx_pkg::NSS_IDLE: begin
            if (is_spi_mst && I_SPI_REQ) begin
               next_q.nss_st = ulx_pkg::NSS_LEAD;
            end
         end
         ulx_pkg::NSS_LEAD: begin
            if (bit_tick) begin
               next_q.nss_st = ulx_pkg::NSS_XFER;
               next_q.spi_go = 1'b1;
            end
         end
         ulx_pkg::NSS_XFER: begin
            if (I_TX_CHAR_DONE) begin
               next_q.nss_st = ulx_pkg::NSS_TRAIL;
            end
         end
         ulx_pkg::NSS_TRAIL: begin
            if (bit_tick) begin
               next_q.nss_st = ulx_pkg::NSS_IDLE;
            end
         end
         default: begin
            next_q.nss_st = ulx_pkg::NSS_IDLE;
         end
      endcase
      // leaving master mode drops any sequence in flight
      if (!is_spi_mst) begin
         next_q.nss_st = ulx_pkg::NSS_IDLE;
      end

      // request-to-send pin carries a different function per mode
      if (is_line_drv) begin
         // next count: the reload at the idle rise must not leave a one-cycle gap
         next_q.rts = ~I_TX_IDLE || (next_q.gcnt != ulx_pkg::BYTE_RESET);
      end else if (is_spi_mst) begin
         // single select output; more slaves need general outputs
         next_q.rts = (next_q.nss_st == ulx_pkg::NSS_IDLE);
      end else if (is_modem) begin
         // request raised while cts holds the transmitter off
         next_q.rts = q.tx_hold;
      end else begin
         next_q.rts = 1'b0;
      end

      // register reads, answered in the following cycle
      next_q.rdata = 32'h0000_0000;
      if (I_RD) begin
         case (I_ADDR)
            ulx_pkg::ADDR_MODE: begin
               next_q.rdata[ulx_pkg::MODE_LSB +: 4] = q.mode;
               next_q.rdata[ulx_pkg::MODE_FILTER_BIT] = q.rx_filt;
               next_q.rdata[ulx_pkg::MODE_NACK_LIM_BIT] = q.nack_lim;
               next_q.rdata[ulx_pkg::MODE_RETRY_EXHAUSTED_FLAG_LSB +: ulx_pkg::RETRY_EXHAUSTED_FLAG_W] = q.max_retry_exhausted_flag;
            end
            ulx_pkg::ADDR_STAT: begin
               next_q.rdata[ulx_pkg::STAT_RETRY] = q.retry_flag;
               next_q.rdata[ulx_pkg::STAT_CHG_LSB +: 4] = q.chg;
               next_q.rdata[ulx_pkg::STAT_LVL_LSB +: 4] = q.lvl[ulx_pkg::IN_W-1:ulx_pkg::IN_CTS];
               next_q.rdata[ulx_pkg::STAT_TX_HOLD] = q.tx_hold;
               next_q.rdata[ulx_pkg::STAT_NSS] = q.rts;
               // read clears the change flags, but a change now survives
               next_q.chg = is_modem ? chg_set : 4'h0;
            end
            ulx_pkg::ADDR_GUARD: begin
               next_q.rdata[7:0] = q.guard;
            end
            ulx_pkg::ADDR_IRF: begin
               next_q.rdata[7:0] = q.ir_filter;
            end
            default: begin
               // command and unmapped addresses read as zero
            end
         endcase
      end
   end

   // state register: synchronous reset, frozen while the clock enable is low
   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RSTN) begin
         q <= '0;
         q.lvl <= '1;
         q.s1 <= '1;
         q.s2 <= '1;
         q.s3 <= '1;
         q.rx_hist <= 2'h3;
         q.rx_prev <= 1'b1;
         q.rx_out <= 1'b1;
         q.tx_bit <= 1'b1;
         q.tx_idle_d <= 1'b1;
         q.dtr <= ulx_pkg::DTR_RESET;
         q.ir_filter <= ulx_pkg::BYTE_RESET;
         q.nss_st <= ulx_pkg::NSS_IDLE;
      end else if (I_CLK_EN) begin
         q <= next_q;
      end
   end

   // outputs straight from the state
   assign O_RDATA = q.rdata;
   assign O_RX_SERIAL = q.rx_out;
   assign O_TX_RESEND = q.resend;
   assign O_RX_SEND_NACK = q.nack;
   assign O_RX_ACCEPT = q.accept;
   assign O_TX_HOLD = q.tx_hold;
   assign O_SPI_GO = q.spi_go;
   assign O_IR_MODE = is_ir;
   assign O_SPI_MASTER = is_spi_mst;
   assign O_SPI_SLAVE = is_spi_slv;
   assign O_TXD = q.txd;
   assign O_RTS = q.rts;
   assign O_DTR = q.dtr;

endmodule // ulx_line_ext

// ==== bench/ulx_asserts.sv ====
// checker for the line-mode extension block, bound to its top ports.
// assumes the clock enable stays high, so every mode write lands.
module ulx_asserts (
   // clock and reset
   input wire logic I_CORE_CLK,
   input wire logic I_RSTN,
   // register port
   input wire logic [7:0] I_ADDR,
   input wire logic [31:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   input wire logic [31:0] O_RDATA,
   // core handshakes
   input wire logic I_TX_IDLE,
   input wire logic I_TX_CHAR_DONE,
   input wire logic I_TX_NACK,
   input wire logic I_RX_CHAR_DONE,
   input wire logic I_RX_PAR_ERR,
   input wire logic O_TX_RESEND,
   input wire logic O_RX_SEND_NACK,
   input wire logic O_RX_ACCEPT,
   input wire logic O_IR_MODE,
   input wire logic O_SPI_MASTER,
   input wire logic O_SPI_SLAVE,
   // pins
   input wire logic O_RTS,
   input wire logic O_DTR
);
   logic [3:0] md;  // mirror of the mode code
   logic cmd_wr;    // write to the command register
   logic ld;        // line-driver mode active
   assign cmd_wr = I_WR && I_ADDR == ulx_pkg::ADDR_CMD;
   assign ld = md == ulx_pkg::MODE_LINE_DRV;
   // mirror the mode field so the decodes can be judged from the ports alone
   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RSTN) md <= 4'h0;
      else if (I_WR && I_ADDR == ulx_pkg::ADDR_MODE) md <= I_WDATA[3:0];
   end
   default clocking cb @(posedge I_CORE_CLK); endclocking
   default disable iff (!I_RSTN);
   read_slot_a: assert property (
      !$past(I_RD) |-> O_RDATA == 32'h0) else $error("read data outside read slot");
   resend_cause_a: assert property (
      O_TX_RESEND |-> $past(I_TX_CHAR_DONE && I_TX_NACK)) else $error("resend without nack");
   clean_no_resend_a: assert property (
      I_TX_CHAR_DONE && !I_TX_NACK |=> !O_TX_RESEND) else $error("resend after clean char");
   nack_cause_a: assert property (
      O_RX_SEND_NACK |-> $past(I_RX_CHAR_DONE && I_RX_PAR_ERR) && !O_RX_ACCEPT)
      else $error("nack without parity error");
   accept_cause_a: assert property (
      O_RX_ACCEPT |-> $past(I_RX_CHAR_DONE)) else $error("accept without character");
   dtr_release_a: assert property (
      $past(cmd_wr && I_WDATA[2]) |-> O_DTR) else $error("terminal ready not released");
   dtr_assert_a: assert property (
      $past(cmd_wr && I_WDATA[1] && !I_WDATA[2]) |-> !O_DTR) else $error("dtr not asserted");
   ir_decode_a: assert property (
      O_IR_MODE == (md == ulx_pkg::MODE_IR)) else $error("infrared decode wrong");
   spi_decode_a: assert property (
      {O_SPI_MASTER, O_SPI_SLAVE} == {md == ulx_pkg::MODE_SPI_MST, md == ulx_pkg::MODE_SPI_SLV})
      else $error("peripheral mode decode wrong");
   line_rts_a: assert property (
      (ld && !I_TX_IDLE) ##1 ld |-> O_RTS) else $error("driver enable low while sending");
endmodule // ulx_asserts

bind ulx_line_ext ulx_asserts u_asserts (.I_CORE_CLK, .I_RSTN, .I_ADDR, .I_WDATA, .I_WR,
   .I_RD, .O_RDATA, .I_TX_IDLE, .I_TX_CHAR_DONE, .I_TX_NACK, .I_RX_CHAR_DONE,
   .I_RX_PAR_ERR, .O_TX_RESEND, .O_RX_SEND_NACK, .O_RX_ACCEPT, .O_IR_MODE, .O_SPI_MASTER,
   .O_SPI_SLAVE, .O_RTS, .O_DTR);

// ==== bench/ulx_far_model.sv ====
// far side model: modem status lines and an infrared light pulse source.
// assumes the bench asks for one pulse at a time and holds the levels between.
module ulx_far_model (
   // clock and requests from the bench
   input wire logic clk,
   input wire logic [3:0] i_lvl,  // cts, dsr, dcd, ri levels wanted
   input wire logic i_go,         // start one low light pulse
   input wire logic [7:0] i_len,  // pulse length in cycles
   input wire logic [7:0] i_gap,  // first cycle of a two-cycle glitch, zero for none
   // pins towards the block
   output logic o_rxd,
   output logic [3:0] o_lvl
);
   logic [7:0] cnt = 8'h00;  // cycles left in the pulse
   // lines move just after the edge, like a real modem on the same board
   always @(posedge clk) begin
      o_lvl <= i_lvl;
      if (i_go) cnt <= i_len;
      else if (cnt != 8'h00) cnt <= cnt - 8'h01;
   end
   // idle line is high; the pin synchroniser swallows single cycles, so the
   // glitch is two cycles long to reach the counter reload path
   always_comb o_rxd = cnt == 8'h00 || (i_gap != 8'h00 && (cnt == i_gap || cnt == i_gap - 8'h01));
endmodule // ulx_far_model

// ==== bench/ulx_line_ext_tb_top.sv ====
// self-checking bench for the line-mode extension block and its far side.
// assumes an oversample tick every second clock and the clock enable held high.
module ulx_line_ext_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // stimulus, idle at time zero
   logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, tick = 1'b0, txs = 1'b1;
   logic idle = 1'b1, busy = 1'b0, tdone = 1'b0, tnack = 1'b0, rdone = 1'b0;
   logic perr = 1'b0, sreq = 1'b0, go = 1'b0, flag, f0, f1;
   logic [7:0] addr = 8'h00, flen = 8'h00, fgap = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, d, r;
   logic [3:0] want = 4'hF, lvl;  // cts, dsr, dcd, ri
   // block outputs
   logic rxd, rxs, res, snack, acc, hold, spigo, txd, rts, dtr;
   int bad_count = 0, comparisons = 0, seed, lim, tc, rc, n, w, m, lowc, pc;
   ulx_line_ext DUT (.I_CORE_CLK(clk), .I_RSTN(rstn), .I_CLK_EN(1'b1), .I_ADDR(addr),
      .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_OS_TICK(tick),
      .I_TX_SERIAL(txs), .I_TX_IDLE(idle), .I_TX_BUSY(busy), .I_TX_CHAR_DONE(tdone),
      .I_TX_NACK(tnack), .I_RX_CHAR_DONE(rdone), .I_RX_PAR_ERR(perr), .I_SPI_REQ(sreq),
      .O_RX_SERIAL(rxs), .O_TX_RESEND(res), .O_RX_SEND_NACK(snack), .O_RX_ACCEPT(acc),
      .O_TX_HOLD(hold), .O_SPI_GO(spigo), .O_IR_MODE(), .O_SPI_MASTER(), .O_SPI_SLAVE(),
      .I_RXD(rxd), .I_CTS(lvl[0]), .I_DSR(lvl[1]), .I_DCD(lvl[2]), .I_RI(lvl[3]),
      .O_TXD(txd), .O_RTS(rts), .O_DTR(dtr));
   ulx_far_model far (.clk(clk), .i_lvl(want), .i_go(go), .i_len(flen), .i_gap(fgap),
      .o_rxd(rxd), .o_lvl(lvl));
   always #12.5 clk = ~clk;
   // tick every second clock keeps the bit timing exact
   always @(posedge clk) tick <= ~tick;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wreg(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask
   task automatic rreg(input logic [7:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   // one character end on both directions; a nack comes in the guard time
   task automatic chars(input logic tn, input logic pe);
      @(posedge clk);
      {tdone, tnack, rdone, perr} <= {1'b1, tn, 1'b1, pe};
      @(posedge clk);
      {tdone, rdone} <= 2'b00;
      #1;
   endtask
   // waits for the select line (sel high) or the transfer start (sel low)
   task automatic wait_hi(input logic sel);
      n = 0;
      while ((sel ? rts : spigo) !== 1'b1 && n < 40) begin
         @(posedge clk);
         #1 n++;
      end
   endtask
   // counts receive-low cycles, transmit pulses and the widest pulse
   task automatic watch(input int cyc);
      {lowc, pc, w, m} = '0;
      repeat (cyc) begin
         @(posedge clk);
         #1 lowc += (rxs === 1'b0);
         if (txd === 1'b1) w++;
         else if (w > 0) begin
            pc++;
            m = (w > m) ? w : m;
            w = 0;
         end
      end
   endtask
   // expected retry or nack for one character; count and flag follow the failure run
   function automatic logic step(input logic fail, inout int c, inout logic f);
      step = fail && c < lim;
      if (!fail) c = 0;
      else if (step) c++;
      else begin
         f = 1'b1;
         c = 0;
      end
   endfunction
   task automatic wrap_up;
      if (bad_count == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      wrap_up();
   end
   initial begin
      seed = 32'h250D98A7;
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      rreg(8'h08);
      chk(d, 32'h0);  // unmapped address reads as zero
      chk({dtr, rxs}, 2'b11);  // reset levels of the pins
      // random nack runs, then a forced run past the limit and clean characters
      lim = 1 + ($unsigned($random(seed)) % 3);
      wreg(ulx_pkg::ADDR_MODE, (32'(lim) << 8) | 32'h20);
      {tc, rc, flag} = '0;
      for (int i = 0; i < 70; i++) begin
         r = $random(seed);
         f0 = (i < 60) ? r[1:0] != 2'b00 : i < 67;
         f1 = (i < 60) ? r[3:2] != 2'b00 : i < 67;
         chars(f0, f1);
         chk(res, step(f0, tc, flag));
         chk({snack, acc}, step(f1, rc, flag) ? 2'b10 : 2'b01);
      end
      rreg(ulx_pkg::ADDR_STAT);
      chk(d[0], flag);
      wreg(ulx_pkg::ADDR_CMD, 32'h1);
      rreg(ulx_pkg::ADDR_STAT);
      chk(d[0], 1'b0);
      // terminal lines
      wreg(ulx_pkg::ADDR_MODE, 32'h3);
      wreg(ulx_pkg::ADDR_CMD, 32'h2);
      chk(dtr, 1'b0);
      wreg(ulx_pkg::ADDR_CMD, 32'h6);
      chk(dtr, 1'b1);
      for (int i = 0; i < 4; i++) begin
         want[i] <= ~want[i];
         rreg(ulx_pkg::ADDR_CMD);
         repeat (8) @(posedge clk);
         rreg(ulx_pkg::ADDR_STAT);
         chk({d[11:8], d[5:2]}, {want, 4'h1 << i});
         rreg(ulx_pkg::ADDR_STAT);
         chk(d[5:2], 4'h0);
      end
      busy <= 1'b1;
      want[0] <= 1'b1;
      repeat (10) @(posedge clk);
      #1 chk(hold, 1'b0);
      busy <= 1'b0;
      chars(1'b0, 1'b0);
      repeat (6) @(posedge clk);
      #1 chk({hold, rts}, 2'b11);
      // demodulator: glitched pulse plain and filtered, then a plain long pulse;
      // the majority keeps a two-sample glitch, so both glitched runs reload
      wreg(ulx_pkg::ADDR_IRF, 32'h0A);
      for (int f = 0; f < 3; f++) begin
         wreg(ulx_pkg::ADDR_MODE, (f == 1) ? 32'h18 : 32'h8);
         {go, flen, fgap} <= {1'b1, 8'h0E, (f == 2) ? 8'h00 : 8'h07};
         @(posedge clk);
         go <= 1'b0;
         watch(80);  // transmit serial held high while receiving
         chk((f == 2) ? lowc >= 30 && lowc <= 34 : lowc == 0, 1'b1);
      end
      // modulator: four zero bits, then ones
      txs <= 1'b0;
      watch(128);
      n = pc;
      chk(m, 6);
      txs <= 1'b1;
      watch(72);
      chk(n + pc >= 4 && n + pc <= 5, 1'b1);
      // line driver enable with a two bit guard
      wreg(ulx_pkg::ADDR_GUARD, 32'h2);
      wreg(ulx_pkg::ADDR_MODE, 32'h1);
      idle <= 1'b0;
      repeat (5) @(posedge clk);
      idle <= 1'b1;
      #1 chk(rts, 1'b1);
      @(posedge clk);
      #1 chk(rts, 1'b1);  // no gap as the guard count loads
      repeat (29) @(posedge clk);
      #1 chk(rts, 1'b1);
      repeat (70) @(posedge clk);
      #1 chk(rts, 1'b0);
      // master select line around one transfer
      wreg(ulx_pkg::ADDR_MODE, 32'hE);
      sreq <= 1'b1;
      @(posedge clk);
      sreq <= 1'b0;
      #1 chk(rts, 1'b0);
      wait_hi(1'b0);
      chk(n <= 33, 1'b1);
      chars(1'b0, 1'b0);
      chk(rts, 1'b0);
      wait_hi(1'b1);
      chk(n <= 34, 1'b1);
      wreg(ulx_pkg::ADDR_MODE, 32'hF);
      wrap_up();
   end
endmodule // ulx_line_ext_tb_top
